// ===== rtl/cpu_register_file.sv
// Programmer-visible register file: special registers, banked sets, address output
`timescale 1ns/1ps
module cpu_register_file
  import regfile_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire rf_ctrl_s    ctl_i,
  input  wire addr_ctrl_s  addr_ctl_i,
  input  wire logic [7:0]  alu_flags_i,
  input  wire logic [3:0]  gen_rd_idx_i,
  input  wire gen_pair_e   gen_rd_pair_i,
  input  wire word_sel_e   word_rd_sel_i,
  output logic [15:0]      addr_o,
  output logic             dram_cycle_flag_b_o,
  output logic [15:0]      program_counter_o,
  output logic [15:0]      stack_pointer_o,
  output logic [15:0]      index_base_first_o,
  output logic [15:0]      index_base_second_o,
  output logic [7:0]       vector_page_o,
  output logic [7:0]       cycle_step_count_o,
  output logic [7:0]       acc_o,
  output logic [7:0]       flags_o,
  output logic             zero_o,
  output logic [7:0]       gen_byte_o,
  output logic [15:0]      word_o,
  output logic             af_bank_o,
  output logic             gen_bank_o
);

  // ****************************************
  // Special purpose registers
  // ****************************************
  logic [15:0] pc_r;
  logic [15:0] sp_r;
  logic [15:0] ixf_r;
  logic [15:0] ixs_r;
  logic [7:0]  vpage_r;
  logic [7:0]  step_r;
  logic [7:0]  step_nxt;
  logic        af_bank_r;
  logic        gen_bank_r;
  logic [7:0]  acc_r  [2];
  logic [7:0]  flag_r [2];
  logic [15:0] gen_pair_q;
  logic [15:0] word_r;

  // Jump load wins over the increment
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_r <= PC_RST;
    end else if (ctl_i.pc_load) begin
      pc_r <= ctl_i.pc_val;
    end else if (ctl_i.pc_inc) begin
      pc_r <= pc_r + PC_STEP;
    end
  end

  // Stack grows downward; pop undoes the matching push so LIFO order holds
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sp_r <= SP_RST;
    end else if (ctl_i.sp_load) begin
      sp_r <= ctl_i.sp_val;
    end else if (ctl_i.push && !ctl_i.pop) begin
      sp_r <= sp_r - SP_STEP;
    end else if (ctl_i.pop && !ctl_i.push) begin
      sp_r <= sp_r + SP_STEP;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ixf_r <= {BYTE_RST, BYTE_RST};
      ixs_r <= {BYTE_RST, BYTE_RST};
    end else begin
      if (ctl_i.ixf_load) begin
        ixf_r <= ctl_i.idx_val;
      end
      if (ctl_i.ixs_load) begin
        ixs_r <= ctl_i.idx_val;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vpage_r <= VPAGE_RST;
    end else if (ctl_i.vpage_load) begin
      vpage_r <= ctl_i.byte_val;
    end
  end

  // ****************************************
  // Refresh counter
  // ****************************************
  // Top bit is only ever changed by an explicit load or by reset
  always_comb begin
    step_nxt = step_r;
    if (ctl_i.step_load) begin
      step_nxt = ctl_i.byte_val;
    end else if (ctl_i.fetch_done) begin
      step_nxt = {step_r[STEP_MSB], step_r[6:0] + STEP_INC};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      step_r <= STEP_RST;
    end else begin
      step_r <= step_nxt;
    end
  end

  // ****************************************
  // Banked accumulator/flags
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      af_bank_r <= 1'b0;
    end else if (ctl_i.ex_af) begin
      af_bank_r <= !af_bank_r;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gen_bank_r <= 1'b0;
    end else if (ctl_i.ex_gen) begin
      gen_bank_r <= !gen_bank_r;
    end
  end

  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_af
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          acc_r[b]  <= BYTE_RST;
          flag_r[b] <= BYTE_RST;
        end else if (af_bank_r == 1'(b)) begin
          if (ctl_i.acc_load) begin
            acc_r[b] <= ctl_i.byte_val;
          end
          if (ctl_i.flag_load) begin
            flag_r[b] <= alu_flags_i;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // General register banks
  // ****************************************
  gen_bank_mem u_gen (
    .mclk_i       (mclk_i),
    .rst_b_i      (rst_b_i),
    .bank_i       (gen_bank_r),
    .we_i         (ctl_i.gen_we),
    .idx_i        (ctl_i.gen_idx),
    .wdata_i      (ctl_i.byte_val),
    .pair_we_i    (ctl_i.gen_pair_we),
    .pair_i       (ctl_i.gen_pair),
    .pair_wdata_i (ctl_i.idx_val),
    .rd_idx_i     (gen_rd_idx_i),
    .rd_pair_i    (gen_rd_pair_i),
    .rdata_o      (gen_byte_o),
    .pair_rdata_o (gen_pair_q)
  );

  // Word read port is registered so it aligns with the general bank read
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_r <= PC_RST;
    end else begin
      unique case (word_rd_sel_i)
        WSRC_PC:  word_r <= pc_r;
        WSRC_SP:  word_r <= sp_r;
        WSRC_IXF: word_r <= ixf_r;
        WSRC_IXS: word_r <= ixs_r;
        default:  word_r <= PC_RST;
      endcase
    end
  end

  assign word_o = (word_rd_sel_i == WSRC_GEN) ? gen_pair_q : word_r;

  // ****************************************
  // Address bus
  // ****************************************
  addr_gen u_addr (
    .mclk_i              (mclk_i),
    .rst_b_i             (rst_b_i),
    .ctl_i               (addr_ctl_i),
    .pc_i                (pc_r),
    .sp_i                (sp_r),
    .ixf_i               (ixf_r),
    .ixs_i               (ixs_r),
    .vpage_i             (vpage_r),
    .step_i              (step_r),
    .addr_o              (addr_o),
    .dram_cycle_flag_b_o (dram_cycle_flag_b_o)
  );

  assign program_counter_o   = pc_r;
  assign stack_pointer_o     = sp_r;
  assign index_base_first_o  = ixf_r;
  assign index_base_second_o = ixs_r;
  assign vector_page_o       = vpage_r;
  assign cycle_step_count_o  = step_r;
  assign acc_o               = acc_r[af_bank_r];
  assign flags_o             = flag_r[af_bank_r];
  assign zero_o              = flag_r[af_bank_r][ZERO_FLAG];
  assign af_bank_o           = af_bank_r;
  assign gen_bank_o          = gen_bank_r;

endmodule

// ===== rtl/regfile_pkg.sv
// Constants and carrier types for the processor register file
package regfile_pkg;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int          BYTE_W       = 8;
  localparam int          WORD_W       = 16;
  localparam int          REG_BITS     = 208;
  localparam logic [15:0] PC_RST       = 16'h0000;
  localparam logic [15:0] SP_RST       = 16'hFFFF;
  localparam logic [7:0]  VPAGE_RST    = 8'h00;
  localparam logic [7:0]  STEP_RST     = 8'h00;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [15:0] PC_STEP      = 16'h0001;
  localparam logic [15:0] SP_STEP      = 16'h0002;
  localparam logic [6:0]  STEP_INC     = 7'h01;
  localparam int          STEP_MSB     = 7;
  localparam int          ZERO_FLAG    = 6;
  localparam int          GEN_ENTRIES  = 12;

  // ****************************************
  // Selectors
  // ****************************************
  typedef enum logic [1:0] {
    PAIR_BC = 2'b00,
    PAIR_DE = 2'b01,
    PAIR_HL = 2'b10
  } gen_pair_e;

  typedef enum logic [2:0] {
    WSRC_PC  = 3'b000,
    WSRC_SP  = 3'b001,
    WSRC_IXF = 3'b010,
    WSRC_IXS = 3'b011,
    WSRC_GEN = 3'b100
  } word_sel_e;

  typedef enum logic [1:0] {
    ADDR_PC      = 2'b00,
    ADDR_SP      = 2'b01,
    ADDR_IDX     = 2'b10,
    ADDR_VECTOR  = 2'b11
  } addr_src_e;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        pc_load;
    logic [15:0] pc_val;
    logic        pc_inc;
    logic        sp_load;
    logic [15:0] sp_val;
    logic        push;
    logic        pop;
    logic        ixf_load;
    logic        ixs_load;
    logic [15:0] idx_val;
    logic        vpage_load;
    logic        step_load;
    logic        fetch_done;
    logic        acc_load;
    logic        flag_load;
    logic [7:0]  byte_val;
    logic        gen_we;
    logic [3:0]  gen_idx;
    logic        gen_pair_we;
    gen_pair_e   gen_pair;
    logic        ex_af;
    logic        ex_gen;
  } rf_ctrl_s;

  typedef struct packed {
    logic        refresh;
    addr_src_e   src;
    logic        idx_second;
    logic [7:0]  disp;
    logic [7:0]  vec_low;
  } addr_ctrl_s;

endpackage

// ===== rtl/gen_bank_mem.sv
// Two banks of six general byte registers with registered read
`timescale 1ns/1ps
module gen_bank_mem
  import regfile_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        bank_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  idx_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        pair_we_i,
  input  wire gen_pair_e   pair_i,
  input  wire logic [15:0] pair_wdata_i,
  input  wire logic [3:0]  rd_idx_i,
  input  wire gen_pair_e   rd_pair_i,
  output logic [7:0]       rdata_o,
  output logic [15:0]      pair_rdata_o
);

  logic [7:0] mem_r [GEN_ENTRIES];
  logic [3:0] hi_idx;
  logic [3:0] lo_idx;
  logic [3:0] rd_hi;

  // Entry = bank*6 + byte; pair hi byte is even, lo byte odd
  assign hi_idx = (bank_i ? 4'h6 : 4'h0) + {1'b0, pair_i, 1'b0};
  assign lo_idx = hi_idx + 4'h1;
  assign rd_hi  = (bank_i ? 4'h6 : 4'h0) + {1'b0, rd_pair_i, 1'b0};

  genvar g;
  generate
    for (g = 0; g < GEN_ENTRIES; g++) begin : g_ent
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          mem_r[g] <= BYTE_RST;
        end else if (pair_we_i && hi_idx == 4'(g)) begin
          mem_r[g] <= pair_wdata_i[15:8];
        end else if (pair_we_i && lo_idx == 4'(g)) begin
          mem_r[g] <= pair_wdata_i[7:0];
        end else if (we_i && (bank_i ? 4'h6 : 4'h0) + idx_i == 4'(g)) begin
          mem_r[g] <= wdata_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o      <= BYTE_RST;
      pair_rdata_o <= {BYTE_RST, BYTE_RST};
    end else begin
      rdata_o      <= mem_r[(bank_i ? 4'h6 : 4'h0) + rd_idx_i];
      pair_rdata_o <= {mem_r[rd_hi], mem_r[rd_hi + 4'h1]};
    end
  end

endmodule

// ===== rtl/addr_gen.sv
// Address bus source selection and effective address arithmetic
`timescale 1ns/1ps
module addr_gen
  import regfile_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire addr_ctrl_s  ctl_i,
  input  wire logic [15:0] pc_i,
  input  wire logic [15:0] sp_i,
  input  wire logic [15:0] ixf_i,
  input  wire logic [15:0] ixs_i,
  input  wire logic [7:0]  vpage_i,
  input  wire logic [7:0]  step_i,
  output logic [15:0]      addr_o,
  output logic             dram_cycle_flag_b_o
);

  logic [15:0] base;
  logic [15:0] eff;
  logic [15:0] addr_nxt;

  assign base = ctl_i.idx_second ? ixs_i : ixf_i;
  assign eff  = base + {{8{ctl_i.disp[7]}}, ctl_i.disp};

  always_comb begin
    addr_nxt = pc_i;
    if (ctl_i.refresh) begin
      addr_nxt = {vpage_i, step_i};
    end else begin
      unique case (ctl_i.src)
        ADDR_PC:     addr_nxt = pc_i;
        ADDR_SP:     addr_nxt = sp_i;
        ADDR_IDX:    addr_nxt = eff;
        ADDR_VECTOR: addr_nxt = {vpage_i, ctl_i.vec_low};
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_o              <= PC_RST;
      dram_cycle_flag_b_o <= 1'b1;
    end else begin
      addr_o              <= addr_nxt;
      dram_cycle_flag_b_o <= !ctl_i.refresh;
    end
  end

endmodule

// ===== dv/regfile_checker.sv
// Concurrent checks on the register file ports
`timescale 1ns/1ps
module regfile_checker
  import regfile_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire rf_ctrl_s    ctl_i,
  input wire addr_ctrl_s  addr_ctl_i,
  input wire logic [7:0]  alu_flags_i,
  input wire logic [15:0] addr_o,
  input wire logic        dram_cycle_flag_b_o,
  input wire logic [15:0] program_counter_o,
  input wire logic [15:0] stack_pointer_o,
  input wire logic [7:0]  vector_page_o,
  input wire logic [7:0]  cycle_step_count_o,
  input wire logic [7:0]  flags_o,
  input wire logic        zero_o,
  input wire logic        af_bank_o,
  input wire logic        gen_bank_o
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  property p_pc_inc;
    ctl_i.pc_inc && !ctl_i.pc_load |=> program_counter_o == $past(program_counter_o) + PC_STEP;
  endproperty
  property p_pc_load;
    ctl_i.pc_load |=> program_counter_o == $past(ctl_i.pc_val);
  endproperty
  property p_pc_addr;
    addr_ctl_i.src == ADDR_PC && !addr_ctl_i.refresh |=> addr_o == $past(program_counter_o);
  endproperty
  property p_step;
    ctl_i.fetch_done && !ctl_i.step_load |=> cycle_step_count_o ==
      {$past(cycle_step_count_o[7]), $past(cycle_step_count_o[6:0]) + STEP_INC};
  endproperty
  property p_dram_cycle_flag;
    addr_ctl_i.refresh |=> !dram_cycle_flag_b_o &&
      addr_o == {$past(vector_page_o), $past(cycle_step_count_o)};
  endproperty
  property p_vec;
    addr_ctl_i.src == ADDR_VECTOR && !addr_ctl_i.refresh |=>
      addr_o == {$past(vector_page_o), $past(addr_ctl_i.vec_low)};
  endproperty
  property p_push;
    ctl_i.push && !ctl_i.pop && !ctl_i.sp_load |=>
      stack_pointer_o == $past(stack_pointer_o) - SP_STEP;
  endproperty
  property p_pop;
    ctl_i.pop && !ctl_i.push && !ctl_i.sp_load |=>
      stack_pointer_o == $past(stack_pointer_o) + SP_STEP;
  endproperty
  property p_ex_af;
    ctl_i.ex_af |=> af_bank_o != $past(af_bank_o);
  endproperty
  property p_ex_gen;
    ctl_i.ex_gen |=> gen_bank_o != $past(gen_bank_o);
  endproperty
  // A bank swap in the same cycle would hide the stored flags, so it is excluded
  property p_zero;
    ctl_i.flag_load && !ctl_i.ex_af |=> flags_o == $past(alu_flags_i) &&
      zero_o == $past(alu_flags_i[ZERO_FLAG]);
  endproperty

  a_pc_inc: assert property (p_pc_inc) else $error("pc increment wrong");
  a_pc_load: assert property (p_pc_load) else $error("pc jump load wrong");
  a_pc_addr: assert property (p_pc_addr) else $error("fetch address wrong");
  a_step: assert property (p_step) else $error("refresh count step wrong");
  a_dram_cycle_flag: assert property (p_dram_cycle_flag) else $error("refresh cycle wrong");
  a_vec: assert property (p_vec) else $error("vector address wrong");
  a_push: assert property (p_push) else $error("push pointer wrong");
  a_pop: assert property (p_pop) else $error("pop pointer wrong");
  a_ex_af: assert property (p_ex_af) else $error("acc bank not toggled");
  a_ex_gen: assert property (p_ex_gen) else $error("gen bank not toggled");
  a_zero: assert property (p_zero) else $error("flag capture wrong");

  c_dram_cycle_flag: cover property (addr_ctl_i.refresh);
  c_stack: cover property (ctl_i.push ##1 ctl_i.pop);
  c_ex: cover property (ctl_i.ex_gen);
endmodule

bind cpu_register_file regfile_checker chk (.mclk_i, .rst_b_i, .ctl_i, .addr_ctl_i,
  .alu_flags_i, .addr_o,
  .dram_cycle_flag_b_o, .program_counter_o, .stack_pointer_o, .vector_page_o,
  .cycle_step_count_o, .flags_o, .zero_o, .af_bank_o, .gen_bank_o);

// ===== dv/alu_model.sv
// Behavioural adder standing in for the ALU that feeds the flags
`timescale 1ns/1ps
module alu_model
  import regfile_pkg::*;
(
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  output logic [7:0]      sum_o,
  output logic [7:0]      flags_o
);
  always_comb begin
    sum_o = a_i + b_i;
    flags_o = 8'h00;
    flags_o[ZERO_FLAG] = (sum_o == 8'h00);
  end
endmodule

// ===== dv/cpu_register_file_tb.sv
// Directed testbench for the register file
`timescale 1ns/1ps
module cpu_register_file_tb
  import regfile_pkg::*;
;
  // ****************************************
  // Stimulus and observation
  // ****************************************
  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  rf_ctrl_s    ctl = '0;
  addr_ctrl_s  actl = '0;
  rf_ctrl_s    c = '0;
  addr_ctrl_s  a = '0;
  logic [7:0]  x = 8'h00;
  logic [7:0]  y = 8'h00;
  logic [3:0]  rd_idx = 4'h0;
  gen_pair_e   rd_pair = PAIR_BC;
  word_sel_e   wsel = WSRC_PC;
  logic [7:0]  sum, aflags, vp, step, acc, flags, gbyte;
  logic [15:0] addr, pc, sp, ixf, ixs, word;
  logic        rfl_b, zero;
  int          bad_count = 0;
  int          comparisons = 0;

  always #20 mclk_i = ~mclk_i;

  cpu_register_file DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ctl_i(ctl),
    .addr_ctl_i(actl), .alu_flags_i(aflags), .gen_rd_idx_i(rd_idx),
    .gen_rd_pair_i(rd_pair), .word_rd_sel_i(wsel), .addr_o(addr),
    .dram_cycle_flag_b_o(rfl_b), .program_counter_o(pc), .stack_pointer_o(sp),
    .index_base_first_o(ixf), .index_base_second_o(ixs), .vector_page_o(vp),
    .cycle_step_count_o(step), .acc_o(acc), .flags_o(flags), .zero_o(zero),
    .gen_byte_o(gbyte), .word_o(word), .af_bank_o(), .gen_bank_o());

  alu_model ALU (.a_i(x), .b_i(y), .sum_o(sum), .flags_o(aflags));

  // Applies the staged command for exactly one rising edge, then clears the stage
  task nx;
    ctl = c;
    actl = a;
    @(negedge mclk_i);
    c = '0;
    a = '0;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task final_report;
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #(40 * 400);
    bad_count++;
    final_report;
  end

  initial begin
    int i;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_b_i = 1'b1;
    chk(pc, 16'h0000);
    chk(vp, 8'h00);
    chk(step, 8'h00);
    chk(sp, 16'hFFFF);
    c.vpage_load = 1'b1; c.byte_val = 8'hA5; nx;
    c.step_load = 1'b1; c.fetch_done = 1'b1; c.byte_val = 8'hFF; nx;
    chk(vp, 8'hA5);
    chk(step, 8'hFF);
    c.pc_inc = 1'b1; c.fetch_done = 1'b1; nx;
    chk(pc, 16'h0001);
    chk(addr, 16'h0000);
    chk(step, 8'h80);
    a.refresh = 1'b1; nx;
    chk(addr, 16'hA580);
    chk(rfl_b, 1'b0);
    nx;
    chk(rfl_b, 1'b1);
    c.pc_load = 1'b1; c.pc_inc = 1'b1; c.pc_val = 16'h1234; nx;
    chk(pc, 16'h1234);
    c.push = 1'b1; nx;
    c.push = 1'b1; nx;
    chk(sp, 16'hFFFB);
    c.pop = 1'b1; nx;
    chk(sp, 16'hFFFD);
    c.push = 1'b1;
    c.pop = 1'b1;
    nx;
    chk(sp, 16'hFFFD);
    c.sp_load = 1'b1; c.push = 1'b1; c.sp_val = 16'h8000; nx;
    chk(sp, 16'h8000);
    c.ixf_load = 1'b1; c.idx_val = 16'h1000; nx;
    c.ixs_load = 1'b1; c.idx_val = 16'h2000; a.src = ADDR_IDX; a.disp = 8'h80; nx;
    chk(ixf, 16'h1000);
    chk(ixs, 16'h2000);
    chk(addr, 16'h0F80);
    a.src = ADDR_IDX; a.idx_second = 1'b1; a.disp = 8'h7F; nx;
    chk(addr, 16'h207F);
    a.src = ADDR_VECTOR; a.vec_low = 8'h3C; nx;
    chk(addr, 16'hA53C);
    // Partner sum of F0 and 10 wraps to zero, so the zero flag must be set
    x = 8'hF0; y = 8'h10; nx;
    c.acc_load = 1'b1; c.flag_load = 1'b1; c.byte_val = sum; nx; nx;
    chk(acc, 8'h00);
    chk(zero, 1'b1);
    chk(flags, 8'(1 << ZERO_FLAG));
    c.ex_af = 1'b1; y = 8'h01; nx;
    c.acc_load = 1'b1; c.flag_load = 1'b1; c.byte_val = sum; nx; nx;
    chk(acc, 8'hF1);
    chk(zero, 1'b0);
    chk(flags, 8'h00);
    c.ex_af = 1'b1; nx; nx;
    chk(acc, 8'h00);
    chk(zero, 1'b1);
    for (i = 0; i < 3; i++) begin
      c.gen_pair_we = 1'b1; c.gen_pair = gen_pair_e'(i);
      c.idx_val = {8'(2 * i + 1), 8'(2 * i + 2)}; nx;
    end
    for (i = 0; i < 6; i++) begin
      rd_idx = 4'(i); nx;
      chk(gbyte, 16'(i + 1));
    end
    c.ex_gen = 1'b1; nx;
    c.gen_we = 1'b1; c.gen_idx = 4'h0; c.byte_val = 8'h77; nx;
    rd_idx = 4'h0; wsel = WSRC_GEN; rd_pair = PAIR_BC; nx;
    chk(gbyte, 8'h77);
    chk(word, 16'h7700);
    c.ex_gen = 1'b1; nx; nx;
    chk(word, 16'h0102);
    wsel = WSRC_SP; nx;
    chk(word, 16'h8000);
    a.src = ADDR_SP;
    wsel = WSRC_IXS;
    nx;
    chk(addr, 16'h8000);
    chk(word, 16'h2000);
    wsel = WSRC_IXF;
    nx;
    chk(word, 16'h1000);
    wsel = WSRC_PC;
    nx;
    chk(word, 16'h1234);
    // Second reset in mid-run must clear registers that now hold non-zero values
    rst_b_i = 1'b0;
    nx;
    rst_b_i = 1'b1;
    chk(pc, 16'h0000);
    chk(vp, 8'h00);
    chk(step, 8'h00);
    final_report;
  end
endmodule
